// File: rtl/ritc_top.sv
// Register integrity checker and transfer protection behind an Avalon-MM slave
// Function
// - Reset-zero enable switches on register checker
// - Monitored register change sets integrity error flag
// - Writing enable zero clears integrity error
// - Mode, checksum and status registers unmonitored
// - Write to monitored register while enabled errors
// - Protection select 00 disables all transfer checking
// - Select 01: XOR on reads, CRC writes
// - Select 10: CRC on reads and writes
// - Protection adds one check byte per transfer
// - Reserved bits four and one read zero
// - XOR of user registers gives 24-bit checksum
// - Checksum reads zero while checker disabled
//
// Decided for this implementation: register access over Avalon-MM and the register offsets.
module ritc_top
  import ritc_pkg::*;
#(
  parameter int         NUM_USER = 4,             // Monitored user registers
  parameter logic [7:0] POLY     = RITC_CRC_POLY  // CRC polynomial
) (
  input  wire logic        clk_in,                // System clock, 100 MHz
  input  wire logic        sys_rst_in,            // Asynchronous reset, active high
  input  wire logic [7:0]  avs_address_in,        // Byte address
  input  wire logic        avs_read_in,           // Read request
  input  wire logic        avs_write_in,          // Write request
  input  wire logic [31:0] avs_writedata_in,      // Write data, check byte in [31:24]
  input  wire logic [3:0]  avs_byteenable_in,     // Byte lanes
  output logic      [31:0] avs_readdata_out,      // Read data, check byte in [31:24]
  output logic             avs_waitrequest_out,   // Stall
  output logic             irq_out                // Level interrupt
);

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration check: user registers must fit the index window
  if (NUM_USER < 1 || NUM_USER > 8) begin : g_bad_num
    $error("NUM_USER must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    ritc_bus_t                    bus;            // Bus answer state
    logic [31:0]                  rdata;          // Registered read word
    logic [NUM_USER-1:0][23:0]    user;           // Monitored user registers
    logic                         wl16;           // Mode bit 0, storage only
    logic [1:0]                   prot;           // Transfer protection select
    logic                         chk_en;         // Integrity checker enable
    logic                         stat_app;       // Mode bit 6, storage only
    logic                         err;            // Integrity error flag
    logic [RITC_NUM_EV-1:0]       int_st;         // Sticky events
    logic [RITC_NUM_EV-1:0]       int_en;         // Event enables
  } ritc_top_state_t;

  ritc_top_state_t st;                            // Current state
  ritc_top_state_t next_st;                       // Next state

  logic [5:0]  idx;                               // Word index of request
  logic        wr_done;                           // Write completes at this edge
  logic        rd_take;                           // Read word captured at this edge
  logic        user_sel;                          // Index hits a user register
  logic [2:0]  user_num;                          // Which user register
  logic [23:0] fold;                              // XOR of all user registers
  logic [23:0] chk_view;                          // Checksum as software sees it
  logic [23:0] mode_view;                         // Mode register as software sees it
  logic [23:0] rd_word;                           // Selected read value
  logic [7:0]  rd_xor;                            // Read check bytes
  logic [7:0]  rd_crc;
  logic [7:0]  wr_xor;                            // Write check bytes
  logic [7:0]  wr_crc;
  logic        wr_bad;                            // Write check byte mismatch
  logic        wr_ok;                             // Write accepted into registers
  logic        mon_change;                        // Monitor saw a change
  logic        ev_integ;                          // Integrity error being raised

  ////////////////////////////////////////////////////////////////////////////////
  // Decode and views
  always_comb begin
    idx      = avs_address_in[7:2];
    user_sel = (idx >= RITC_IDX_USER0) && (idx < RITC_IDX_USER0 + 6'(NUM_USER));
    user_num = 3'(idx - RITC_IDX_USER0);
    // Reads capture while the stall is up, so the word already stands when it drops;
    // writes wait for the answer cycle so they take effect at the completing edge
    wr_done  = (st.bus == RITC_BUS_DONE) && avs_write_in;
    rd_take  = (st.bus == RITC_BUS_IDLE) && avs_read_in;
    // Only user registers feed the fold, so mode and status stay outside it
    fold = '0;
    for (int i = 0; i < NUM_USER; i++) begin
      fold = fold ^ st.user[i];
    end
    chk_view = st.chk_en ? fold : 24'h000000;
    // Reserved bits 4 and 1 are never stored, so they always read zero
    mode_view = '0;
    mode_view[RITC_IF_WL16_BIT]                      = st.wl16;
    mode_view[RITC_IF_PROT_LSB +: 2]                 = st.prot;
    mode_view[RITC_IF_CHKEN_BIT]                     = st.chk_en;
    mode_view[RITC_IF_STAT_BIT]                      = st.stat_app;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read word selection; unmapped and write-only indices read zero
  always_comb begin
    rd_word = 24'h000000;
    case (idx)
      RITC_IDX_IFMODE:     rd_word = mode_view;
      RITC_IDX_CHECKSUM:   rd_word = chk_view;
      RITC_IDX_STATUS:     rd_word = {23'h000000, st.err};
      RITC_IDX_INT_STATUS: rd_word = {22'h000000, st.int_st};
      RITC_IDX_INT_ENABLE: rd_word = {22'h000000, st.int_en};
      default: begin
        if (user_sel) begin
          rd_word = st.user[user_num];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Check bytes: message is the index byte followed by the 24 data bits
  ritc_check_byte #(
    .POLY    (POLY),
    .INIT    (RITC_CRC_INIT)
  ) u_rd_check (
    .msg_in  ({2'b00, idx, rd_word}),
    .xor_out (rd_xor),
    .crc_out (rd_crc)
  );

  ritc_check_byte #(
    .POLY    (POLY),
    .INIT    (RITC_CRC_INIT)
  ) u_wr_check (
    .msg_in  ({2'b00, idx, avs_writedata_in[23:0]}),
    .xor_out (wr_xor),
    .crc_out (wr_crc)
  );

  // Writes are CRC checked under any non-zero select, including the XOR mode
  always_comb begin
    wr_bad = (st.prot != RITC_PROT_OFF) &&
             (avs_writedata_in[31:24] != wr_crc);
    wr_ok  = wr_done && !wr_bad;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Integrity monitor
  ritc_monitor u_monitor (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .enable_in  (st.chk_en),
    .fold_in    (fold),
    .wr_hit_in  (wr_ok && user_sel),
    .change_out (mon_change)
  );

  // Event only on the error's rise; a standing error must not re-raise the sticky bit
  // after software has cleared it, or the interrupt could never be acknowledged
  assign ev_integ = mon_change && !st.err;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: bus answer, register writes, flags
  always_comb begin
    next_st = st;
    // Answer one cycle after the request; a request is never taken twice
    case (st.bus)
      RITC_BUS_IDLE: begin
        if (avs_read_in || avs_write_in) begin
          next_st.bus = RITC_BUS_DONE;
        end
      end
      RITC_BUS_DONE: begin
        next_st.bus = RITC_BUS_IDLE;
      end
      default: begin
        next_st.bus = RITC_BUS_IDLE;
      end
    endcase
    // Read word plus check byte; the byte lane is zero when unprotected
    if (rd_take) begin
      case (st.prot)
        RITC_PROT_OFF: next_st.rdata = {8'h00, rd_word};
        RITC_PROT_XOR: next_st.rdata = {rd_xor, rd_word};
        default:       next_st.rdata = {rd_crc, rd_word};
      endcase
    end
    // Register writes take effect at the completing edge only
    if (wr_ok) begin
      case (idx)
        RITC_IDX_IFMODE: begin
          if (avs_byteenable_in[0]) begin
            next_st.wl16     = avs_writedata_in[RITC_IF_WL16_BIT];
            next_st.prot     = avs_writedata_in[RITC_IF_PROT_LSB +: 2];
            next_st.chk_en   = avs_writedata_in[RITC_IF_CHKEN_BIT];
            next_st.stat_app = avs_writedata_in[RITC_IF_STAT_BIT];
          end
        end
        RITC_IDX_INT_ENABLE: begin
          if (avs_byteenable_in[0]) begin
            next_st.int_en = avs_writedata_in[RITC_NUM_EV-1:0];
          end
        end
        RITC_IDX_INT_CLEAR: begin
          if (avs_byteenable_in[0]) begin
            next_st.int_st = st.int_st & ~avs_writedata_in[RITC_NUM_EV-1:0];
          end
        end
        default: begin
          if (user_sel) begin
            next_st.user[user_num] = ritc_merge(st.user[user_num], avs_writedata_in,
                                                avs_byteenable_in);
          end
        end
      endcase
    end
    // Disabling the checker drops a pending integrity error
    if (!next_st.chk_en) begin
      next_st.err = 1'b0;
    end
    // Setting wins over any clear in the same cycle
    if (mon_change) begin
      next_st.err = 1'b1;
    end
    if (ev_integ) begin
      next_st.int_st[RITC_EV_INTEG] = 1'b1;
    end
    if (wr_done && wr_bad) begin
      next_st.int_st[RITC_EV_WRCHK] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st          <= '0;
      st.bus      <= RITC_BUS_IDLE;
      st.prot     <= RITC_PROT_RST;
      st.chk_en   <= RITC_CHKEN_RST;
      st.user     <= {NUM_USER{RITC_USER_RST}};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    // Stall is combinational so it covers the request's first cycle with no delay
    avs_waitrequest_out = (avs_read_in || avs_write_in) && (st.bus == RITC_BUS_IDLE);
    avs_readdata_out    = st.rdata;
    irq_out             = |(st.int_st & st.int_en);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_chk_en_reset;
    @(posedge clk_in) sys_rst_in |=> !st.chk_en && st.prot == RITC_PROT_RST;
  endproperty
  a_chk_en_reset: assert property (p_chk_en_reset)
    else $error("Enable or select not zero after reset");

  property p_change_flags;
    @(posedge clk_in) disable iff (sys_rst_in) mon_change |=> st.err;
  endproperty
  a_change_flags: assert property (p_change_flags)
    else $error("Change did not set integrity error");

  property p_clear_on_disable;
    @(posedge clk_in) disable iff (sys_rst_in)
      (wr_ok && idx == RITC_IDX_IFMODE && avs_byteenable_in[0] &&
       !avs_writedata_in[RITC_IF_CHKEN_BIT]) |=> !st.err && !st.chk_en;
  endproperty
  a_clear_on_disable: assert property (p_clear_on_disable)
    else $error("Integrity error survived disable");

  property p_mode_not_monitored;
    @(posedge clk_in) disable iff (sys_rst_in)
      (wr_ok && idx == RITC_IDX_IFMODE && !st.err && !mon_change &&
       avs_writedata_in[RITC_IF_CHKEN_BIT]) |=> !st.err;
  endproperty
  a_mode_not_monitored: assert property (p_mode_not_monitored)
    else $error("Mode register write raised integrity error");

  property p_user_write_err;
    @(posedge clk_in) disable iff (sys_rst_in)
      (wr_ok && user_sel && st.chk_en && $past(st.chk_en)) |=> st.err;
  endproperty
  a_user_write_err: assert property (p_user_write_err)
    else $error("Monitored write while enabled not flagged");

  property p_unprot_read;
    @(posedge clk_in) disable iff (sys_rst_in)
      (rd_take && st.prot == RITC_PROT_OFF) |=> avs_readdata_out[31:24] == 8'h00;
  endproperty
  a_unprot_read: assert property (p_unprot_read)
    else $error("Check byte present with protection off");

  property p_xor_read;
    @(posedge clk_in) disable iff (sys_rst_in)
      (rd_take && st.prot == RITC_PROT_XOR) |=>
        avs_readdata_out[31:24] == ritc_xor8({2'b00, $past(idx), avs_readdata_out[23:0]});
  endproperty
  a_xor_read: assert property (p_xor_read)
    else $error("Read XOR checksum byte wrong");

  property p_bad_write_blocked;
    @(posedge clk_in) disable iff (sys_rst_in)
      (wr_done && wr_bad && user_sel) |=>
        st.int_st[RITC_EV_WRCHK] && st.user == $past(st.user);
  endproperty
  a_bad_write_blocked: assert property (p_bad_write_blocked)
    else $error("Write with bad CRC was not refused");

  property p_reserved_zero;
    @(posedge clk_in) disable iff (sys_rst_in) !mode_view[4] && !mode_view[1];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved mode bit reads non-zero");

  property p_chk_zero;
    @(posedge clk_in) disable iff (sys_rst_in)
      !st.chk_en |-> chk_view == 24'h000000 ##1 (st.chk_en || chk_view == 24'h000000);
  endproperty
  a_chk_zero: assert property (p_chk_zero)
    else $error("Checksum non-zero while disabled");

  property p_answer_next;
    @(posedge clk_in) disable iff (sys_rst_in)
      avs_waitrequest_out |=> !avs_waitrequest_out;
  endproperty
  a_answer_next: assert property (p_answer_next)
    else $error("Bus answer later than one cycle");

  c_integ_err: cover property (@(posedge clk_in) disable iff (sys_rst_in) ev_integ);
  c_crc_read:  cover property (@(posedge clk_in) disable iff (sys_rst_in)
                               rd_take && st.prot == RITC_PROT_CRC);
  c_bad_write: cover property (@(posedge clk_in) disable iff (sys_rst_in) wr_done && wr_bad);
  c_irq:       cover property (@(posedge clk_in) disable iff (sys_rst_in) irq_out);

endmodule : ritc_top

// File: rtl/ritc_pkg.sv
// Shared constants, types and helper functions of the register integrity block
package ritc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register word indices (byte address is four times the index)
  localparam logic [5:0] RITC_IDX_IFMODE     = 6'h00; // Interface mode control
  localparam logic [5:0] RITC_IDX_CHECKSUM   = 6'h01; // Integrity checksum value
  localparam logic [5:0] RITC_IDX_STATUS     = 6'h02; // Status, integrity error flag
  localparam logic [5:0] RITC_IDX_INT_STATUS = 6'h03; // Sticky event bits, read-only
  localparam logic [5:0] RITC_IDX_INT_CLEAR  = 6'h04; // Write one to clear, write-only
  localparam logic [5:0] RITC_IDX_INT_ENABLE = 6'h05; // Event enable mask
  localparam logic [5:0] RITC_IDX_USER0      = 6'h08; // First monitored user register

  ////////////////////////////////////////////////////////////////////////////////
  // Interface mode field positions and reset values
  localparam int          RITC_IF_WL16_BIT   = 0;     // Plain storage bit
  localparam int          RITC_IF_PROT_LSB   = 2;     // Protection select [3:2]
  localparam int          RITC_IF_CHKEN_BIT  = 5;     // Integrity checker enable
  localparam int          RITC_IF_STAT_BIT   = 6;     // Plain storage bit
  localparam logic [1:0]  RITC_PROT_OFF      = 2'h0;  // No transfer protection
  localparam logic [1:0]  RITC_PROT_XOR      = 2'h1;  // XOR on reads, CRC on writes
  localparam logic [1:0]  RITC_PROT_CRC      = 2'h2;  // CRC on reads and writes
  localparam logic [1:0]  RITC_PROT_RST      = 2'h0;  // Protection select reset
  localparam logic        RITC_CHKEN_RST     = 1'b0;  // Checker enable reset
  localparam logic [23:0] RITC_USER_RST      = 24'h000000;

  ////////////////////////////////////////////////////////////////////////////////
  // Status and event bit positions
  localparam int          RITC_ST_ERR_BIT    = 0;     // Integrity error in status
  localparam int          RITC_EV_INTEG      = 0;     // Event: integrity error raised
  localparam int          RITC_EV_WRCHK      = 1;     // Event: write check byte wrong
  localparam int          RITC_NUM_EV        = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Check byte defaults (polynomial x^8+x^2+x+1 by default, parameter per instance)
  localparam logic [7:0]  RITC_CRC_POLY      = 8'h07;
  localparam logic [7:0]  RITC_CRC_INIT      = 8'h00;

  // Bus answer states, one-hot
  typedef enum logic [1:0] {
    RITC_BUS_IDLE = 2'b01,
    RITC_BUS_DONE = 2'b10
  } ritc_bus_t;

  // XOR of the four bytes of a message
  function automatic logic [7:0] ritc_xor8(input logic [31:0] msg);
    return msg[31:24] ^ msg[23:16] ^ msg[15:8] ^ msg[7:0];
  endfunction : ritc_xor8

  // Merge write data into a 24-bit register under the byte enables
  function automatic logic [23:0] ritc_merge(input logic [23:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
    logic [23:0] res;
    res = old;
    for (int b = 0; b < 3; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return res;
  endfunction : ritc_merge

endpackage : ritc_pkg

// File: rtl/ritc_check_byte.sv
// Check byte generator: XOR checksum and parameterised CRC-8 over a 32-bit message
module ritc_check_byte
  import ritc_pkg::*;
#(
  parameter logic [7:0] POLY = RITC_CRC_POLY, // CRC generator polynomial
  parameter logic [7:0] INIT = RITC_CRC_INIT  // CRC start value
) (
  input  wire logic [31:0] msg_in,            // Index byte and 24 data bits
  output logic      [7:0]  xor_out,           // XOR checksum byte
  output logic      [7:0]  crc_out            // CRC byte
);

  ////////////////////////////////////////////////////////////////////////////////
  // Bitwise CRC, MSB first; polynomial kept a parameter since it may vary per part
  function automatic logic [7:0] crc8(input logic [31:0] msg);
    logic [7:0] c;
    c = INIT;
    for (int i = 31; i >= 0; i--) begin
      if (c[7] ^ msg[i]) begin
        c = {c[6:0], 1'b0} ^ POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : crc8

  // Both bytes are pure logic; the caller registers the read byte it uses and compares the write CRC unregistered
  always_comb begin
    xor_out = ritc_xor8(msg_in);
    crc_out = crc8(msg_in);
  end

endmodule : ritc_check_byte

// File: rtl/ritc_monitor.sv
// Integrity monitor: snapshot of the user checksum and change detector
module ritc_monitor (
  input  wire logic        clk_in,      // System clock
  input  wire logic        sys_rst_in,  // Asynchronous reset, active high
  input  wire logic        enable_in,   // Integrity checker enable
  input  wire logic [23:0] fold_in,     // Live checksum of monitored registers
  input  wire logic        wr_hit_in,   // Completed write to a monitored register
  output logic             change_out   // Change seen while armed
);

  ////////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic        armed;                 // Snapshot valid
    logic [23:0] snap;                  // Checksum taken when enabled
  } ritc_mon_state_t;

  ritc_mon_state_t st;                  // Current state
  ritc_mon_state_t next_st;             // Next state

  // Arm one cycle after enable rises; host has finished configuring by then
  always_comb begin
    next_st       = st;
    next_st.armed = enable_in;
    if (enable_in && !st.armed) begin
      next_st.snap = fold_in;
    end
    // Any write counts, even one that rewrites the same value
    change_out = st.armed && enable_in &&
                 ((fold_in != st.snap) || wr_hit_in);
  end

  // Register the state
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : ritc_monitor

// File: tb/ritc_host.sv
// Host bus master model: register transfers over Avalon-MM with check bytes
module ritc_host (
  input  wire logic        clk_in,                // Bus clock
  input  wire logic        waitrequest_in,        // Slave stall
  input  wire logic [31:0] readdata_in,           // Slave read data
  output logic      [7:0]  address_out   = 8'h00, // Byte address
  output logic             read_out      = 1'b0,  // Read request
  output logic             write_out     = 1'b0,  // Write request
  output logic      [31:0] writedata_out = 32'h0, // Check byte in lane 3
  output logic      [3:0]  byteenable_out = 4'hf  // Byte lanes of the request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] prot = 2'h0; // Select the host believes is active

  // Bitwise CRC-8, poly 0x07, init 0, top bit first
  function automatic logic [7:0] crc8(input logic [31:0] m);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ m[i]) == 1'b1) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc8

  // One transfer; request held until waitrequest is seen low at a rising edge
  task automatic xfer(input bit wr, input logic [5:0] idx, input logic [23:0] d,
                      input bit bad, input logic [3:0] lanes, output logic [31:0] q);
    logic [7:0] chk;
    chk = (prot != 2'h0) ? (crc8({2'b00, idx, d}) ^ {8{bad}}) : 8'h00;
    @(posedge clk_in);
    address_out    <= {idx, 2'b00};
    read_out       <= !wr;
    write_out      <= wr;
    writedata_out  <= {chk, d};
    byteenable_out <= lanes;
    // Waitrequest is looked at on the rising edge only; no cycle count is assumed
    do begin
      @(posedge clk_in);
    end while (waitrequest_in !== 1'b0);
    q = readdata_in;
    read_out      <= 1'b0;
    write_out     <= 1'b0;
    writedata_out <= ~writedata_out; // Released lanes keep moving, never stale
  endtask : xfer
endmodule : ritc_host

// File: tb/tb.sv
// Testbench of the register integrity block
module tb
  import ritc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [7:0]  adr;
  logic        rd_s, wr_s, wreq, irq;
  logic [31:0] wd, rdat, q;
  logic [3:0]  be;
  logic [23:0] usr [4];
  logic [23:0] fold;
  int          bad_count = 0;
  int          comparisons = 0;
  int          k;

  always #5 clk_in = ~clk_in;

  ritc_top i_ritc_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .avs_address_in(adr),
    .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wd),
    .avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
    .irq_out(irq));
  ritc_host i_ritc_host (.clk_in(clk_in), .waitrequest_in(wreq), .readdata_in(rdat),
    .address_out(adr), .read_out(rd_s), .write_out(wr_s), .writedata_out(wd),
    .byteenable_out(be));

  // Compare and count; four-state so an unknown never matches
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [5:0] idx, input logic [23:0] d, input bit bad = 1'b0,
                    input logic [3:0] lanes = 4'hf);
    i_ritc_host.xfer(1'b1, idx, d, bad, lanes, q);
  endtask : wr

  task automatic rd(input logic [5:0] idx);
    i_ritc_host.xfer(1'b0, idx, 24'h0, 1'b0, 4'hf, q);
  endtask : rd

  // Read check byte the slave should append for a select value
  function automatic logic [7:0] exp_chk(input logic [1:0] p, input logic [31:0] m);
    if (p == 2'h1) begin
      return m[31:24] ^ m[23:16] ^ m[15:8] ^ m[7:0];
    end
    return (p == 2'h0) ? 8'h00 : i_ritc_host.crc8(m);
  endfunction : exp_chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #50us;
    bad_count++;
    give_verdict();
  end

  initial begin
    q = $urandom(70);
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    foreach (usr[i]) begin
      rd(6'(i));
      check("reset value", q, 32'h0);
    end
    check("irq after reset", 32'(irq), 32'h0);
    $display("test reset done");
    // Program users with checker off, then arm; reserved bits ignored
    fold = 24'h0;
    foreach (usr[i]) begin
      usr[i] = 24'($urandom);
      fold ^= usr[i];
      wr(RITC_IDX_USER0 + 6'(i), usr[i]);
    end
    wr(RITC_IDX_INT_ENABLE, 24'h3);
    wr(RITC_IDX_IFMODE, 24'h32);
    rd(RITC_IDX_IFMODE);
    check("mode reserved", q, 32'h20);
    rd(RITC_IDX_CHECKSUM);
    check("checksum", q, {8'h0, fold});
    wr(RITC_IDX_IFMODE, 24'h20);
    rd(RITC_IDX_STATUS);
    check("status mode write", q, 32'h0);
    k = $urandom_range(3);
    wr(RITC_IDX_USER0 + 6'(k), usr[k]);
    rd(RITC_IDX_STATUS);
    check("status after rewrite", q, 32'h1);
    check("irq integrity", 32'(irq), 32'h1);
    wr(RITC_IDX_IFMODE, 24'h0);
    rd(RITC_IDX_STATUS);
    check("status cleared", q, 32'h0);
    rd(RITC_IDX_CHECKSUM);
    check("checksum off", q, 32'h0);
    // Single-lane write with the checker off: only the low byte may move
    wr(RITC_IDX_USER0 + 6'h2, ~usr[2], 1'b0, 4'h1);
    usr[2][7:0] = ~usr[2][7:0];
    rd(RITC_IDX_USER0 + 6'h2);
    check("lane write", q, {8'h0, usr[2]});
    wr(RITC_IDX_INT_CLEAR, 24'h1);
    rd(RITC_IDX_STATUS);
    check("irq cleared", 32'(irq), 32'h0);
    $display("test integrity done");
    // Selects 01 and 10: read check byte, refused bad write
    for (int p = 1; p <= 2; p++) begin
      wr(RITC_IDX_IFMODE, 24'(p << 2));
      i_ritc_host.prot = 2'(p);
      rd(RITC_IDX_USER0);
      check("read check byte", q, {exp_chk(2'(p), {2'b00, RITC_IDX_USER0, usr[0]}), usr[0]});
      wr(RITC_IDX_USER0 + 6'h1, ~usr[1], 1'b1);
      rd(RITC_IDX_USER0 + 6'h1);
      check("bad write refused", {8'h0, q[23:0]}, {8'h0, usr[1]});
      check("write check irq", 32'(irq), 32'h1);
      rd(RITC_IDX_INT_STATUS);
      check("write check event", {8'h0, q[23:0]}, 32'h2);
      wr(RITC_IDX_INT_CLEAR, 24'h2);
      wr(RITC_IDX_IFMODE, 24'h0);
      i_ritc_host.prot = 2'h0;
      rd(RITC_IDX_USER0);
      check("no check byte", q, {8'h0, usr[0]});
      $display("test protection %0d done", p);
    end
    give_verdict();
  end
endmodule : tb
